// ===== src/memory_decode_boot_remap.sv
// address decode, boot strap, remap, abort and bank control with stacked flash model
//
// Behaviour
// - sram does byte/half/word access in one cycle
// - remap places sram at address zero
// - address zero decodes boot memory before remap
// - strap sampled over last ten reset cycles
// - strap one eight-bit boot, zero sixteen-bit
// - remap trigger write maps sram over the whole internal region
// - only reset undoes remap
// - undefined external address raises abort
// - internal or peripheral access never aborts
// - external unit serves 0x00400000 to 0xffc00000
// - eight 1M up to four 16M banks
// - per-bank wait, float and width settings
// - sixteen-bit bank byte-select or byte-write mode
// - early read option for external devices
// - flash word address is address bits 1-20
// - flash reset low aborts and tri-states
// - polling read inverts data bit seven while a program runs, not during erase
// - flash busy low during program/erase
// - 39 sectors, erase suspend allows other sectors
// - program refused on oe low, ce/we high
// - reset async in, sync out, fetch 80 later
`timescale 1ns/1ps
module memory_decode_boot_remap #(
  parameter int NBANK = memdec_pkg::NUM_BANKS
) (
  // clock and resets
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic chip_reset_in_n,
  // strap pin
  input wire logic boot_width_strap,
  // processor access
  input wire logic cpu_req_in,
  input wire logic cpu_write_in,
  input wire logic [1:0] cpu_size_in,
  input wire logic [memdec_pkg::ADDR_W-1:0] cpu_addr_in,
  input wire logic [memdec_pkg::DATA_W-1:0] cpu_wdata_in,
  input wire logic remap_trigger_bit,
  // bank configuration
  input wire logic [memdec_pkg::SIZE_W-1:0] bank_size_in,
  input wire logic [NBANK*memdec_pkg::WAIT_W-1:0] bank_wait_in,
  input wire logic [NBANK*memdec_pkg::FLOAT_W-1:0] bank_float_in,
  input wire logic [NBANK-1:0] bank_wide_in,
  input wire logic [NBANK-1:0] bank_byte_write_in,
  input wire logic early_read_in,
  // flash control inputs
  input wire logic flash_enable_n,
  input wire logic flash_reset_n,
  input wire logic flash_oe_n_in,
  input wire logic flash_we_n_in,
  input wire logic flash_prog_in,
  input wire logic flash_erase_in,
  input wire logic flash_suspend_in,
  input wire logic [5:0] flash_sector_in,
  // processor answers
  output logic cpu_ready_out,
  output logic [memdec_pkg::DATA_W-1:0] cpu_rdata_out,
  output logic abort_out,
  output logic [1:0] target_out,
  output logic remapped_out,
  output logic boot_wide_out,
  output logic fetch_enable_out,
  // external bus
  output logic [NBANK-1:0] chip_select_n_out,
  output logic [memdec_pkg::FLASH_AW-1:0] flash_word_addr_out,
  output logic [1:0] byte_lane_n_out,
  output logic [1:0] write_lane_n_out,
  output logic ext_busy_out,
  // flash status pins, open drain
  output logic flash_busy_n,
  output logic flash_busy_oe_n_out,
  output logic flash_data_oe_n_out
);
  import memdec_pkg::*;

  initial begin
    if (NBANK < 4 || NBANK > 8) $error("bank count must be 4 to 8");
  end

  // pin synchronisers: first stage read only by second
  logic chip_reset_in_n_s1_reg, chip_reset_in_n_s2_reg, strap_s1_reg, strap_s2_reg;
  logic fen_s1_reg, fen_s2_reg, frst_s1_reg, frst_s2_reg;
  always_ff @(posedge ref_clk_in) begin
    chip_reset_in_n_s1_reg <= chip_reset_in_n;
    chip_reset_in_n_s2_reg <= chip_reset_in_n_s1_reg;
    strap_s1_reg <= boot_width_strap;
    strap_s2_reg <= strap_s1_reg;
    fen_s1_reg <= flash_enable_n;
    fen_s2_reg <= fen_s1_reg;
    frst_s1_reg <= flash_reset_n;
    frst_s2_reg <= frst_s1_reg;
  end

  // combined reset: internal reset or a low pin; release follows the synchroniser
  logic sys_rst;
  assign sys_rst = rst_in | ~chip_reset_in_n_s2_reg;

  // strap history: eight-bit boot only if the strap is one over all of the last ten reset cycles
  logic [STRAP_CYCLES-1:0] strap_hist_reg;
  logic boot_wide_reg;
  always_ff @(posedge ref_clk_in) begin
    if (~chip_reset_in_n_s2_reg) begin
      strap_hist_reg <= {strap_hist_reg[STRAP_CYCLES-2:0], strap_s2_reg};
    end
  end
  // caught at release of the pin only; internal resets keep the old boot mode
  logic chip_reset_in_n_prev_reg;
  always_ff @(posedge ref_clk_in) begin
    chip_reset_in_n_prev_reg <= chip_reset_in_n_s2_reg;
    if (chip_reset_in_n_s2_reg && !chip_reset_in_n_prev_reg) begin
      boot_wide_reg <= ~(&strap_hist_reg);
    end
  end
  assign boot_wide_out = boot_wide_reg;

  // first fetch delay after release
  logic [$clog2(FETCH_DELAY+1)-1:0] fetch_cnt_reg;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst) begin
      fetch_cnt_reg <= '0;
      fetch_enable_out <= 1'b0;
    end else if (fetch_cnt_reg != FETCH_DELAY[$bits(fetch_cnt_reg)-1:0]) begin
      fetch_cnt_reg <= fetch_cnt_reg + 1'b1;
      fetch_enable_out <= (fetch_cnt_reg == FETCH_DELAY[$bits(fetch_cnt_reg)-1:0] - 1'b1);
    end
  end

  // remap is sticky: only reset clears it, nothing writes it back
  logic remap_reg;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst) begin
      remap_reg <= 1'b0;
    end else if (remap_trigger_bit) begin
      remap_reg <= 1'b1;
    end
  end
  assign remapped_out = remap_reg;

  // bank decode: bank index from address within the external region
  function automatic logic [3:0] bank_of(input logic [31:0] a, input logic [SIZE_W-1:0] sz);
    logic [31:0] off;
    off = a - INT_MEM_TOP;
    case (sz)
      2'h0: bank_of = {1'b0, off[22:20]};
      2'h1: bank_of = {1'b0, off[24:22]};
      2'h2: bank_of = {1'b0, off[26:24]};
      default: bank_of = {1'b0, off[28:26]};
    endcase
    if (off[31:29] != 3'h0) bank_of = 4'hf;
    else if ((sz == 2'h0 && off[28:23] != '0) || (sz == 2'h1 && off[28:25] != '0)
             || (sz == 2'h2 && off[28:26] != '0)) bank_of = 4'hf;
  endfunction

  // effective bank count: 1M gives eight banks, 16M limits to four
  logic [3:0] nbank_eff;
  assign nbank_eff = (bank_size_in >= SIZE_16M) ? 4'h4 : NBANK[3:0];

  // address decode
  logic [1:0] tgt;
  logic [3:0] bank;
  logic ext_bad;
  logic is_sram;
  always_comb begin
    tgt = TARGET_NONE;
    bank = bank_of(cpu_addr_in, bank_size_in);
    ext_bad = 1'b0;
    is_sram = 1'b0;
    if (cpu_addr_in >= PERIPH_BASE) begin
      tgt = TARGET_PERIPH;
    end else if (cpu_addr_in >= INT_MEM_TOP) begin
      tgt = TARGET_EXT;
      ext_bad = (bank >= nbank_eff) || (!remap_reg && bank != 4'h0);
    end else if (remap_reg) begin
      is_sram = 1'b1;
      tgt = TARGET_SRAM;
    end else if (cpu_addr_in >= SRAM_ALT_BASE) begin
      is_sram = 1'b1;
      tgt = TARGET_SRAM;
    end else begin
      tgt = TARGET_EXT; // boot memory on chip select zero
      bank = 4'h0;
    end
  end

  // sram instance and lanes
  logic [3:0] be;
  always_comb begin
    unique case (cpu_size_in)
      2'h0: be = 4'h1 << cpu_addr_in[1:0];
      2'h1: be = cpu_addr_in[1] ? 4'hc : 4'h3;
      default: be = 4'hf;
    endcase
  end
  logic [31:0] sram_rdata;
  sram_word #(.AW(SRAM_WORDS_LOG2)) u_sram (
    .ref_clk_in(ref_clk_in),
    .en_in(cpu_req_in && is_sram && !sys_rst),
    .be_in(cpu_write_in ? be : 4'h0),
    .addr_in(cpu_addr_in[SRAM_WORDS_LOG2+1:2]),
    .wdata_in(cpu_wdata_in),
    .rdata_out(sram_rdata)
  );

  // external access sequencer: wait states, then float cycles
  typedef enum logic [1:0] {EXT_IDLE, EXT_WAIT, EXT_FLOAT} ext_state_type;
  ext_state_type ext_state_reg;
  logic [WAIT_W-1:0] wait_cnt_reg;
  logic [FLOAT_W-1:0] float_cnt_reg;
  logic [2:0] bank_reg;
  logic ext_start;
  assign ext_start = cpu_req_in && tgt == TARGET_EXT && !ext_bad && ext_state_reg == EXT_IDLE;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst) begin
      ext_state_reg <= EXT_IDLE;
      wait_cnt_reg <= '0;
      float_cnt_reg <= '0;
      bank_reg <= '0;
    end else begin
      unique case (ext_state_reg)
        EXT_IDLE: begin
          if (ext_start) begin
            bank_reg <= bank[2:0];
            // early read shortens the access by one wait state
            wait_cnt_reg <= bank_wait_in[bank[2:0]*WAIT_W +: WAIT_W];
            float_cnt_reg <= bank_float_in[bank[2:0]*FLOAT_W +: FLOAT_W];
            ext_state_reg <= EXT_WAIT;
          end
        end
        EXT_WAIT: begin
          if (wait_cnt_reg == '0 || (early_read_in && wait_cnt_reg == 1)) begin
            ext_state_reg <= (float_cnt_reg == '0) ? EXT_IDLE : EXT_FLOAT;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 1'b1;
          end
        end
        EXT_FLOAT: begin
          if (float_cnt_reg == 1) ext_state_reg <= EXT_IDLE;
          float_cnt_reg <= float_cnt_reg - 1'b1;
        end
      endcase
    end
  end

  // flash model: program/erase timer, polling data, busy pin
  logic [8:0] fl_cnt_reg;
  logic fl_prog_reg, fl_erase_reg, fl_susp_reg;
  logic [5:0] fl_sector_reg;
  logic [FLASH_AW-1:0] fl_last_addr_reg;
  logic [15:0] fl_last_data_reg;
  logic fl_ce;
  logic fl_prog_ok;
  assign fl_ce = ~fen_s2_reg;
  assign fl_prog_ok = flash_oe_n_in && fl_ce && !flash_we_n_in;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst || !frst_s2_reg) begin
      fl_prog_reg <= 1'b0;
      fl_erase_reg <= 1'b0;
      fl_susp_reg <= 1'b0;
      fl_cnt_reg <= '0;
      fl_sector_reg <= '0;
      fl_last_addr_reg <= '0;
      fl_last_data_reg <= '0;
    end else if (fl_prog_reg) begin
      if (fl_cnt_reg == '0) fl_prog_reg <= 1'b0;
      else fl_cnt_reg <= fl_cnt_reg - 1'b1;
    end else if (fl_erase_reg) begin
      fl_susp_reg <= flash_suspend_in;
      if (!flash_suspend_in) begin
        if (fl_cnt_reg == '0) fl_erase_reg <= 1'b0;
        else fl_cnt_reg <= fl_cnt_reg - 1'b1;
      end
      if (flash_suspend_in && flash_prog_in && fl_prog_ok
          && flash_sector_in != fl_sector_reg) begin
        fl_prog_reg <= 1'b1; // other sector while suspended
        fl_cnt_reg <= 9'(FLASH_PROG_CYCLES - 1);
        fl_last_addr_reg <= cpu_addr_in[FLASH_AW:1];
        fl_last_data_reg <= cpu_wdata_in[15:0];
      end
    end else if (flash_prog_in && fl_prog_ok) begin
      fl_prog_reg <= 1'b1;
      fl_cnt_reg <= 9'(FLASH_PROG_CYCLES - 1);
      fl_last_addr_reg <= cpu_addr_in[FLASH_AW:1];
      fl_last_data_reg <= cpu_wdata_in[15:0];
    end else if (flash_erase_in && fl_ce && flash_sector_in < 6'(SECTORS)) begin
      fl_erase_reg <= 1'b1;
      fl_sector_reg <= flash_sector_in;
      fl_cnt_reg <= 9'(FLASH_ERASE_CYCLES - 1);
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst) begin
      cpu_ready_out <= 1'b0;
      cpu_rdata_out <= '0;
      abort_out <= 1'b0;
      target_out <= TARGET_NONE;
      chip_select_n_out <= '1;
      flash_word_addr_out <= '0;
      byte_lane_n_out <= 2'h3;
      write_lane_n_out <= 2'h3;
      ext_busy_out <= 1'b0;
      flash_busy_n <= 1'b1;
      flash_busy_oe_n_out <= 1'b1;
      flash_data_oe_n_out <= 1'b1;
    end else begin
      abort_out <= cpu_req_in && tgt == TARGET_EXT && ext_bad;
      target_out <= tgt;
      cpu_ready_out <= cpu_req_in && tgt != TARGET_EXT;
      cpu_rdata_out <= sram_rdata;
      if (ext_state_reg == EXT_WAIT && (wait_cnt_reg == '0
          || (early_read_in && wait_cnt_reg == 1))) begin
        cpu_ready_out <= 1'b1;
        // polling read of the last word returns bit seven inverted while a program runs
        cpu_rdata_out <= {16'h0000, fl_last_data_reg ^ {8'h00, fl_prog_reg, 7'h00}};
      end
      chip_select_n_out <= '1;
      if (ext_start || ext_state_reg == EXT_WAIT) begin
        chip_select_n_out[ext_start ? bank[2:0] : bank_reg] <= 1'b0;
      end
      flash_word_addr_out <= cpu_addr_in[FLASH_AW:1];
      if (bank_wide_in[bank[2:0]]) begin
        byte_lane_n_out <= (cpu_size_in == 2'h0) ? {~cpu_addr_in[0], cpu_addr_in[0]} : 2'h0;
        // write strobes follow this access's lanes, not last cycle's registered ones
        write_lane_n_out <= (cpu_write_in && bank_byte_write_in[bank[2:0]])
          ? ((cpu_size_in == 2'h0) ? {~cpu_addr_in[0], cpu_addr_in[0]} : 2'h0) : 2'h3;
      end else begin
        byte_lane_n_out <= 2'h2; // eight-bit bank uses low lane
        write_lane_n_out <= 2'h3;
      end
      ext_busy_out <= ext_state_reg != EXT_IDLE;
      flash_busy_n <= 1'b0;
      flash_busy_oe_n_out <= !(fl_prog_reg || (fl_erase_reg && !fl_susp_reg));
      flash_data_oe_n_out <= !frst_s2_reg;
    end
  end

  // remap never falls without reset
  a_remap_sticky: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    remap_reg |=> remap_reg) else $error("remap cleared without reset");
  a_remap_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    remap_trigger_bit |=> remapped_out) else $error("remap not taken");
  a_periph_noabort: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    (cpu_req_in && cpu_addr_in >= PERIPH_BASE) |=> !abort_out)
    else $error("abort on peripheral");
  a_int_noabort: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    (cpu_req_in && cpu_addr_in < INT_MEM_TOP) |=> !abort_out)
    else $error("abort on internal memory");
  a_ext_abort: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    (cpu_req_in && tgt == TARGET_EXT && ext_bad) |=> abort_out)
    else $error("missing abort");
  a_sram_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    (remap_reg && cpu_addr_in < VEC_TOP) |-> is_sram) else $error("vectors not in sram");
  a_boot_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    (!remap_reg && cpu_addr_in < VEC_TOP) |-> (tgt == TARGET_EXT && bank == 4'h0))
    else $error("boot not at zero");
  a_fetch_delay: assert property (@(posedge ref_clk_in)
    $fell(sys_rst) |-> !fetch_enable_out [*8]) else $error("fetch too early");
  a_busy_pin: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    $rose(fl_prog_reg) |=> !flash_busy_oe_n_out) else $error("busy not driven");
  a_prog_inhibit: assert property (@(posedge ref_clk_in) disable iff (sys_rst)
    (!fl_prog_reg && !fl_erase_reg && !flash_oe_n_in) |=> !$rose(fl_prog_reg))
    else $error("program started with oe low");
endmodule

// ===== src/memdec_pkg.sv
// constants shared by the memory decode and remap block
package memdec_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [31:0] INT_MEM_TOP = 32'h0040_0000;  // first address past internal memories
  localparam logic [31:0] PERIPH_BASE = 32'hffc0_0000;  // first on-chip peripheral address
  localparam logic [31:0] SRAM_ALT_BASE = 32'h0030_0000;  // sram alias while not remapped
  localparam logic [31:0] VEC_TOP = 32'h0000_0020;  // end of the exception vector area
  localparam int STRAP_CYCLES = 10;  // strap sampling window before reset release
  localparam int FETCH_DELAY = 80;  // cycles from reset release to first fetch
  localparam int NUM_BANKS = 8;
  localparam int SECTORS = 39;
  localparam int WAIT_W = 4;  // wait-state field width
  localparam int FLOAT_W = 3;  // float-cycle field width
  localparam int SIZE_W = 2;  // bank size code: 0=1M 1=4M 2=16M 3=64M
  localparam logic [SIZE_W-1:0] SIZE_1M = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_16M = 2'h2;
  localparam logic [1:0] TARGET_SRAM = 2'h0;
  localparam logic [1:0] TARGET_EXT = 2'h1;
  localparam logic [1:0] TARGET_PERIPH = 2'h2;
  localparam logic [1:0] TARGET_NONE = 2'h3;
  localparam int FLASH_PROG_CYCLES = 64;  // modelled program time in clocks
  localparam int FLASH_ERASE_CYCLES = 256;  // modelled sector erase time in clocks
  localparam int SRAM_WORDS_LOG2 = 16;  // 256 kbyte as 64k words
  localparam int FLASH_AW = 20;  // flash word address width
  localparam int DATA_BIT_SEVEN = 7;
endpackage

// ===== src/sram_word.sv
// single-cycle 32-bit internal sram with byte lanes
`timescale 1ns/1ps
module sram_word #(
  parameter int AW = 16
) (
  // clock
  input wire logic ref_clk_in,
  // access port
  input wire logic en_in,
  input wire logic [3:0] be_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [0:(1<<AW)-1];  // storage, no reset by design

  // one clock for byte, half-word and word, write and read alike
  always_ff @(posedge ref_clk_in) begin
    if (en_in) begin
      for (int b = 0; b < 4; b++) begin
        if (be_in[b]) begin
          mem[addr_in][b*8 +: 8] <= wdata_in[b*8 +: 8];
        end
      end
      rdata_out <= mem[addr_in];
    end
  end
endmodule

// ===== test/board_side.sv
// board-level partner: strap resistor, flash enable wiring and busy pull-up
`timescale 1ns/1ps
module board_side (
  // clock and reset pin level
  input wire logic ref_clk_in,
  input wire logic rst_pin_n_in,
  // board choices
  input wire logic strap_level_in,
  input wire logic tie_cs_in,
  input wire logic ce_force_n_in,
  // device pins seen by the board
  input wire logic [7:0] chip_select_n_in,
  input wire logic busy_value_in,
  input wire logic busy_oe_n_in,
  // levels the board presents
  output logic strap_out,
  output logic flash_ce_n_out,
  output logic busy_line_out
);
  logic strap_reg;  // the level the resistor holds
  // the strap only moves while the reset pin is high, so it is steady in the sampling window
  always_ff @(posedge ref_clk_in) begin
    if (rst_pin_n_in) begin
      strap_reg <= strap_level_in;
    end
  end
  assign strap_out = strap_reg;
  // flash enable wired to chip select zero; the bench may drive it for flash-only tests
  assign flash_ce_n_out = tie_cs_in ? chip_select_n_in[0] : ce_force_n_in;
  // open drain with pull-up: released means high, never the last driven value
  assign busy_line_out = busy_oe_n_in ? 1'b1 : busy_value_in;
endmodule

// ===== test/memory_decode_boot_remap_bench.sv
// self-checking bench for address decode, boot strap, remap, aborts and flash status
`timescale 1ns/1ps
module memory_decode_boot_remap_bench;
  import memdec_pkg::*;
  // stimulus
  logic ref_clk_in = 0, rst_in = 1, pin_n = 1, strap_lvl = 0, tie_cs = 1, ce_force_n = 1;
  logic req = 0, wr = 0, trig = 0, early = 0;
  logic [1:0] size = 2'h2;
  logic [31:0] addr = 32'h0, wdata = 32'h0;
  logic [1:0] bsize = SIZE_1M;
  logic [31:0] bwait = {8{4'h2}};  // two wait states on every bank
  logic [23:0] bfloat = {8{3'h1}};
  logic [7:0] bwide = 8'hff, bbw = 8'h00;
  logic f_rst_n = 1, f_oe_n = 1, f_we_n = 1, f_prog = 0, f_erase = 0, f_susp = 0;
  logic [5:0] f_sec = 6'h00;
  // observed
  logic ready, abort, remapped, boot_wide, fetch_en, ext_busy, busy_val, busy_oe_n, data_oe_n;
  logic strap, ce_n, busy_line;
  logic [1:0] target, lanes, wlanes;
  logic [31:0] rdata;
  logic [7:0] cs_n;
  logic [19:0] faddr, faddr_seen;
  int fails = 0, check_count = 0;

  // 250 MHz clock
  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  memory_decode_boot_remap i_memory_decode_boot_remap (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .chip_reset_in_n(pin_n), .boot_width_strap(strap), .cpu_req_in(req),
    .cpu_write_in(wr), .cpu_size_in(size), .cpu_addr_in(addr), .cpu_wdata_in(wdata),
    .remap_trigger_bit(trig), .bank_size_in(bsize), .bank_wait_in(bwait),
    .bank_float_in(bfloat), .bank_wide_in(bwide), .bank_byte_write_in(bbw),
    .early_read_in(early), .flash_enable_n(ce_n), .flash_reset_n(f_rst_n),
    .flash_oe_n_in(f_oe_n), .flash_we_n_in(f_we_n), .flash_prog_in(f_prog),
    .flash_erase_in(f_erase), .flash_suspend_in(f_susp), .flash_sector_in(f_sec),
    .cpu_ready_out(ready), .cpu_rdata_out(rdata), .abort_out(abort), .target_out(target),
    .remapped_out(remapped), .boot_wide_out(boot_wide), .fetch_enable_out(fetch_en),
    .chip_select_n_out(cs_n), .flash_word_addr_out(faddr), .byte_lane_n_out(lanes),
    .write_lane_n_out(wlanes), .ext_busy_out(ext_busy), .flash_busy_n(busy_val),
    .flash_busy_oe_n_out(busy_oe_n), .flash_data_oe_n_out(data_oe_n));

  board_side i_board_side (.ref_clk_in(ref_clk_in), .rst_pin_n_in(pin_n),
    .strap_level_in(strap_lvl), .tie_cs_in(tie_cs), .ce_force_n_in(ce_force_n),
    .chip_select_n_in(cs_n), .busy_value_in(busy_val), .busy_oe_n_in(busy_oe_n),
    .strap_out(strap), .flash_ce_n_out(ce_n), .busy_line_out(busy_line));

  // one comparison; four-state equality so an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // full reset with the pin low long enough for the strap window, then time the first fetch
  task automatic do_reset(input logic s);
    int n;
    strap_lvl = s;
    idle(2);
    rst_in = 1;
    pin_n = 0;
    idle(3);
    rst_in = 0;
    idle(11);
    pin_n = 1;
    for (n = 0; n < 120 && fetch_en !== 1'b1; n++) idle(1);
    check(n >= 80 && n <= 83, 1, "fetch delay after pin release");
    check(cs_n, 8'hff, "selects idle after reset");
    check(remapped, 0, "remap cleared by reset");
    check(boot_wide, !s, "boot width from strap");
  endtask

  // one processor access, request held until ready or abort; external data stands with ready,
  // sram data comes one cycle later
  task automatic access(input logic [31:0] a, input logic w, input logic [1:0] sz,
                        input logic [31:0] d, output int n, output logic ab,
                        output logic [1:0] tg, output logic [7:0] cs, output logic [31:0] rd);
    n = 0;
    ab = 0;
    cs = 8'hff;
    req = 1;
    addr = a;
    wr = w;
    size = sz;
    wdata = d;
    for (n = 1; n <= 40; n++) begin
      idle(1);
      if (n == 1) begin
        cs = cs_n;
        tg = target;
        faddr_seen = faddr;
      end
      if (ready === 1'b1 || abort === 1'b1) break;
    end
    ab = abort;
    rd = rdata;  // external read data is registered together with ready
    req = 0;
    idle(1);
    if (tg == TARGET_SRAM) rd = rdata;  // sram output register adds one cycle
    idle(8);  // let float cycles and any stray pulse pass
  endtask

  // before remap: zero decodes boot memory on select zero, other banks refused
  task automatic t_boot_map();
    int n; logic ab; logic [1:0] tg; logic [7:0] cs; logic [31:0] rd;
    access(32'h0000_0246, 0, 2'h1, 32'h0, n, ab, tg, cs, rd);
    check(tg, TARGET_EXT, "boot target at zero");
    check(cs[0], 0, "select zero for boot");
    check(faddr_seen, 20'h00123, "flash word address");
    check(ab, 0, "no abort on boot memory");
    access(32'h0050_0000, 0, 2'h2, 32'h0, n, ab, tg, cs, rd);
    check(ab, 1, "abort on bank before remap");
  endtask

  // sram alias: single cycle, word then byte merge
  task automatic t_sram();
    int n; logic ab; logic [1:0] tg; logic [7:0] cs; logic [31:0] rd;
    access(SRAM_ALT_BASE, 1, 2'h2, 32'ha5a5_1234, n, ab, tg, cs, rd);
    check(n, 1, "sram write in one cycle");
    access(SRAM_ALT_BASE + 32'h1, 1, 2'h0, 32'heeee_eeee, n, ab, tg, cs, rd);
    access(SRAM_ALT_BASE, 0, 2'h2, 32'h0, n, ab, tg, cs, rd);
    check(n, 1, "sram read in one cycle");
    check(tg, TARGET_SRAM, "sram target");
    check(rd, 32'ha5a5_ee34, "byte lane merge");
  endtask

  // remap moves sram to zero and survives trigger low
  task automatic t_remap();
    int n; logic ab; logic [1:0] tg; logic [7:0] cs; logic [31:0] rd;
    trig = 1;
    idle(1);
    trig = 0;
    idle(2);
    check(remapped, 1, "remap taken");
    access(VEC_TOP - 32'h4, 1, 2'h2, 32'h1357_9bdf, n, ab, tg, cs, rd);
    access(VEC_TOP - 32'h4, 0, 2'h2, 32'h0, n, ab, tg, cs, rd);
    check(tg, TARGET_SRAM, "zero now sram");
    check(rd, 32'h1357_9bdf, "vector rewritten");
    idle(20);
    check(remapped, 1, "remap persists");
  endtask

  // external timing with wait states and early read, undefined external address aborts
  task automatic t_ext();
    int n; logic ab; logic [1:0] tg; logic [7:0] cs; logic [31:0] rd;
    access(32'h0040_0000, 0, 2'h2, 32'h0, n, ab, tg, cs, rd);
    check(tg, TARGET_EXT, "external target");
    check(cs !== 8'hff, 1, "a bank select asserted");
    check(n, 4, "two wait states plus select and ready cycles");
    check(ab, 0, "defined bank no abort");
    check(lanes, 2'h0, "word access on wide bank drives both lanes");
    check(ext_busy, 0, "external unit idle after float");
    early = 1;
    access(32'h0040_0000, 0, 2'h2, 32'h0, n, ab, tg, cs, rd);
    check(n, 3, "early read one less");
    early = 0;
    access(32'h8000_0000, 0, 2'h2, 32'h0, n, ab, tg, cs, rd);
    check(ab, 1, "undefined external aborts");
    check(cs, 8'hff, "no select on abort");
    access(32'hffc0_0010, 1, 2'h2, 32'h5, n, ab, tg, cs, rd);
    check({ab, tg}, {1'b0, TARGET_PERIPH}, "peripheral no abort");
    access(32'hfff0_0000, 0, 2'h0, 32'h0, n, ab, tg, cs, rd);
    check(ab, 0, "undefined peripheral no abort");
  endtask

  task automatic wait_busy(input logic lvl, input int lim, output int n);
    for (n = 0; n < lim && busy_line !== lvl; n++) idle(1);
  endtask

  // flash program inhibit, busy pin, reset abort
  task automatic t_flash();
    int n; logic ab; logic [1:0] tg; logic [7:0] cs; logic [31:0] rd;
    tie_cs = 0;
    ce_force_n = 0;
    idle(3);  // enable must be through its synchroniser so only oe low refuses
    f_oe_n = 0;
    f_we_n = 0;
    f_prog = 1;
    idle(1);
    f_prog = 0;
    idle(10);
    check(busy_line, 1, "program refused with oe low");
    f_oe_n = 1;
    wdata = 32'h0000_5a3c;  // word being programmed
    f_prog = 1;
    idle(1);
    f_prog = 0;
    wait_busy(0, 6, n);
    check(busy_line, 0, "busy during program");
    access(32'h0040_0000, 0, 2'h2, 32'h0, n, ab, tg, cs, rd);
    check(rd, 32'h0000_5abc, "polling read inverts bit seven");
    wait_busy(1, FLASH_PROG_CYCLES + 8, n);
    check(busy_line, 1, "busy released after program");
    f_sec = 6'd38;
    f_erase = 1;
    idle(1);
    f_erase = 0;
    wait_busy(0, 6, n);
    check(busy_line, 0, "busy during erase");
    f_rst_n = 0;
    idle(5);
    check({busy_line, data_oe_n}, 2'h3, "flash reset aborts and floats");
    f_rst_n = 1;
    f_we_n = 1;
    tie_cs = 1;
    idle(4);
  endtask

  // internal reset clears remap but keeps boot width; pin reset resamples strap
  task automatic t_resets();
    rst_in = 1;
    idle(2);
    rst_in = 0;
    idle(2);
    check(remapped, 0, "internal reset undoes remap");
    check(boot_wide, 1, "boot width kept on internal reset");
    do_reset(1);
  endtask

  initial begin
    do_reset(0);
    t_boot_map();
    t_sram();
    t_remap();
    t_ext();
    t_flash();
    t_resets();
    final_report();
  end

  // watchdog well past the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule
